// File: design/cdd_pkg.sv
// constants and carrier types for the clock distribution dividers
package cdd_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_CH0_COUNTS  = 10'h190;
  localparam logic [9:0] IDX_CH0_PHASE   = 10'h191;
  localparam logic [9:0] IDX_CH0_CTRL    = 10'h192;
  localparam logic [9:0] IDX_CH1_COUNTS  = 10'h196;
  localparam logic [9:0] IDX_CH1_PHASE   = 10'h197;
  localparam logic [9:0] IDX_CH1_CTRL    = 10'h198;
  localparam logic [9:0] IDX_CH2A_COUNTS = 10'h199;
  localparam logic [9:0] IDX_CH2B_COUNTS = 10'h19b;
  localparam logic [9:0] IDX_CH2_BYPASS  = 10'h19c;
  localparam logic [9:0] IDX_CH2_CTRL    = 10'h19d;
  localparam logic [9:0] IDX_CH3A_COUNTS = 10'h19e;
  localparam logic [9:0] IDX_CH3B_COUNTS = 10'h1a0;
  localparam logic [9:0] IDX_CH3_BYPASS  = 10'h1a1;
  localparam logic [9:0] IDX_CH3_CTRL    = 10'h1a2;
  localparam logic [9:0] IDX_PREDIV      = 10'h1e0;
  localparam logic [9:0] IDX_SOURCE      = 10'h1e1;
  localparam logic [9:0] IDX_SYNC_CMD    = 10'h1f0;
  localparam logic [9:0] IDX_STATUS      = 10'h1f1;

  // storage slots
  localparam int NUM_REGS = 16;
  localparam logic [3:0] S_CH0_COUNTS  = 4'h0;
  localparam logic [3:0] S_CH0_PHASE   = 4'h1;
  localparam logic [3:0] S_CH0_CTRL    = 4'h2;
  localparam logic [3:0] S_CH1_COUNTS  = 4'h3;
  localparam logic [3:0] S_CH1_PHASE   = 4'h4;
  localparam logic [3:0] S_CH1_CTRL    = 4'h5;
  localparam logic [3:0] S_CH2A_COUNTS = 4'h6;
  localparam logic [3:0] S_CH2B_COUNTS = 4'h7;
  localparam logic [3:0] S_CH2_BYPASS  = 4'h8;
  localparam logic [3:0] S_CH2_CTRL    = 4'h9;
  localparam logic [3:0] S_CH3A_COUNTS = 4'ha;
  localparam logic [3:0] S_CH3B_COUNTS = 4'hb;
  localparam logic [3:0] S_CH3_BYPASS  = 4'hc;
  localparam logic [3:0] S_CH3_CTRL    = 4'hd;
  localparam logic [3:0] S_PREDIV      = 4'he;
  localparam logic [3:0] S_SOURCE      = 4'hf;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // field positions and codes
  // ---------------------------------------------------------------
  localparam int HIGH_CNT_LSB   = 0;
  localparam int LOW_CNT_LSB    = 4;
  localparam int PHASE_LSB      = 0;
  localparam int START_HIGH_BIT = 4;
  localparam int BYPASS_BIT     = 7;
  localparam int DCC_OFF_BIT    = 0;
  localparam int DIRECT_BIT     = 1;
  localparam int STAGE_A_BYP    = 4;
  localparam int STAGE_B_BYP    = 5;
  localparam int SYNC_BIT       = 0;
  localparam logic [1:0] SRC_EXT_PRE    = 2'h0;
  localparam logic [1:0] SRC_EXT_DIRECT = 2'h1;
  localparam logic [1:0] SRC_OSC_PRE    = 2'h2;
  localparam logic [1:0] SRC_ILLEGAL    = 2'h3;
  localparam logic [2:0] PREDIV_BASE    = 3'h2;
  localparam logic [2:0] PREDIV_MAX     = 3'h6;
  localparam logic [4:0] PHASE_HIGH_ADD = 5'h01;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] high_cnt;
    logic [3:0] low_cnt;
    logic       bypass;
    logic       duty_correct_disable;
    logic       start_high_flag;
    logic [3:0] phase_delay_field;
  } cdd_stage_cfg_t;

  typedef struct packed {
    logic       prev_in;
    logic       hi;
    logic       out;
    logic       pend;
    logic       wait_dly;
    logic [3:0] cnt;
    logic [4:0] dly;
  } cdd_stage_state_t;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic                     ack;
    logic [7:0]               rdata;
    logic [7:0]               outs;
    logic                     sync;
    logic                     src_prev;
    logic [2:0]               pd_cnt;
    logic                     pd_raw;
    logic                     pd_corr;
    logic                     pd_pend;
  } cdd_top_state_t;

endpackage : cdd_pkg

// File: design/cdd_top.sv
// clock distribution dividers: register slave, source select, pre-divider, channel dividers
//
// Summary of operation
// [RULE1] Source code 00 takes external clock via pre-divider; 10 takes oscillator via it.
// [RULE2] Direct bit in channel 0/1 control sends pre-divider input to that output pair.
// [RULE3] Software keeps a pre-divider source code while using the direct route.
// [RULE4] Total ratio equals pre-divider ratio times channel ratio.
// [RULE5] Three-bit pre-divider field selects division by 2 to 6.
// [RULE6] Channels 2 and 3 cascade two 2-to-32 stages; ratio is their product.
// [RULE7] Channel 0 counts, bypass and correction-disable live at their fixed fields.
// [RULE8] Channel 1 counts, bypass and correction-disable live at their fixed fields.
// [RULE9] Count fields are cycles minus one: high N+1, low M+1.
// [RULE10] Bypass passes input through at ratio one and stops the divider.
// [RULE11] Unbypassed divider ratio is N+M+2, any integer 2 to 32.
// [RULE12] All counting uses edges of the clock feeding the divider input.
// [RULE13] Duty correction on by default, disabled per channel by its bit.
// [RULE14] Software sets M=N for even or M=N+1 for odd corrected ratios.
// [RULE15] Without correction, duty is (N+1)/(N+M+2).
// [RULE16] Bypass after odd pre-divider: 33.3% or 40% uncorrected, 50% corrected.
// [RULE17] No pre-divider: bypass keeps input duty; odd gives (N+1+X)/(2N+3).
// [RULE18] Direct route shows oscillator at 50% or external clock at its own duty.
// [RULE19] Rising edge delayed by phase field and start-high bit, plus M when set.
// [RULE20] New phase offsets apply only after a sync; software must issue one.
// [RULE21] Code 01 is external clock without pre-divider; code 11 is not allowed.
// [RULE22] Start-high bit 4 and phase field 3:0 sit in each phase register.
// [RULE23] Odd correction stretches the high phase to the input falling edge.
// [RULE24] After sync the output starts high if start-high is set, else low.
`timescale 1ns/1ps

// ---------------------------------------------------------------
// one 2-to-32 divider stage
// ---------------------------------------------------------------
module cdd_div_stage (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // control
  input  wire logic                    sync_i,
  input  wire cdd_pkg::cdd_stage_cfg_t cfg_i,
  // divider input levels, raw and duty-corrected
  input  wire logic                    in_i,
  input  wire logic                    in_corr_i,
  // divided level
  output logic                         out_o
);

  cdd_pkg::cdd_stage_state_t st;
  cdd_pkg::cdd_stage_state_t next_st;
  logic                      rise;
  logic                      fall;
  logic                      dcc_odd;
  logic [4:0]                dly_load;

  always_comb begin
    next_st = st;
    rise = in_i & ~st.prev_in;  // RULE12
    fall = ~in_i & st.prev_in;
    dcc_odd = ~cfg_i.duty_correct_disable
              && ({1'b0, cfg_i.low_cnt} == {1'b0, cfg_i.high_cnt} + 5'h01);  // RULE13
    if (cfg_i.start_high_flag) begin
      dly_load = {1'b0, cfg_i.phase_delay_field} + {1'b0, cfg_i.low_cnt}
                 + cdd_pkg::PHASE_HIGH_ADD;  // RULE19
    end else begin
      dly_load = {1'b0, cfg_i.phase_delay_field};  // RULE19
    end
    next_st.prev_in = in_i;
    if (cfg_i.bypass) begin
      // divider held still while bypassed
      next_st.hi = 1'b0;  // RULE10
      next_st.out = 1'b0;
      next_st.pend = 1'b0;
      next_st.cnt = 4'h0;
      next_st.dly = 5'h00;
      next_st.wait_dly = 1'b1;
    end else if (sync_i) begin
      // phase and start level taken only here
      next_st.dly = dly_load;  // RULE20
      next_st.out = cfg_i.start_high_flag;  // RULE24
      next_st.hi = 1'b0;
      next_st.pend = 1'b0;
      next_st.cnt = 4'h0;
      next_st.wait_dly = 1'b1;
    end else if (st.wait_dly) begin
      if (rise) begin
        if (st.dly == 5'h00) begin
          next_st.wait_dly = 1'b0;
          next_st.hi = 1'b1;
          next_st.out = 1'b1;
          next_st.cnt = 4'h0;
        end else begin
          next_st.dly = st.dly - 5'h01;  // RULE19
        end
      end
    end else begin
      if (rise) begin
        if (st.hi) begin
          if (st.cnt == cfg_i.high_cnt) begin  // RULE9 RULE11
            next_st.hi = 1'b0;
            next_st.cnt = 4'h0;
            if (dcc_odd) begin
              next_st.pend = 1'b1;  // RULE23
            end else begin
              next_st.out = 1'b0;  // RULE15
            end
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end else begin
          if (st.cnt == cfg_i.low_cnt) begin  // RULE9 RULE11
            next_st.hi = 1'b1;
            next_st.out = 1'b1;
            next_st.pend = 1'b0;
            next_st.cnt = 4'h0;
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end
      end
      if (fall && st.pend) begin
        next_st.out = 1'b0;  // RULE23 RULE17
        next_st.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // bypass: corrected input unless correction is disabled
  assign out_o = cfg_i.bypass ? (cfg_i.duty_correct_disable ? in_i : in_corr_i)  // RULE10
                              : st.out;  // RULE16 RULE17

endmodule : cdd_div_stage

// ---------------------------------------------------------------
// top: wishbone registers, source, pre-divider, four channels
// ---------------------------------------------------------------
module cdd_top (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // clock sources, sampled levels
  input  wire logic        ext_clk_i,
  input  wire logic        osc_clk_i,
  // divided outputs, two per channel
  output logic      [7:0]  clk_out_o
);

  cdd_pkg::cdd_top_state_t st;
  cdd_pkg::cdd_top_state_t next_st;

  cdd_pkg::cdd_stage_cfg_t [5:0] cfg;
  logic [5:0]  stg_in;
  logic [5:0]  stg_corr;
  logic [5:0]  stg_out;
  logic [1:0]  src_sel;
  logic        src_lvl;
  logic        src_legal;
  logic        pre_used;
  logic        src_rise;
  logic        src_fall;
  logic [2:0]  pd_ratio;
  logic [2:0]  pd_next;
  logic        ch_in;
  logic        ch_corr;
  logic        req;
  logic        hit;
  logic [3:0]  slot;
  logic [9:0]  idx;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] reg_slot(input logic [9:0] a);
    case (a)
      cdd_pkg::IDX_CH0_COUNTS:  reg_slot = {1'b1, cdd_pkg::S_CH0_COUNTS};
      cdd_pkg::IDX_CH0_PHASE:   reg_slot = {1'b1, cdd_pkg::S_CH0_PHASE};
      cdd_pkg::IDX_CH0_CTRL:    reg_slot = {1'b1, cdd_pkg::S_CH0_CTRL};
      cdd_pkg::IDX_CH1_COUNTS:  reg_slot = {1'b1, cdd_pkg::S_CH1_COUNTS};
      cdd_pkg::IDX_CH1_PHASE:   reg_slot = {1'b1, cdd_pkg::S_CH1_PHASE};
      cdd_pkg::IDX_CH1_CTRL:    reg_slot = {1'b1, cdd_pkg::S_CH1_CTRL};
      cdd_pkg::IDX_CH2A_COUNTS: reg_slot = {1'b1, cdd_pkg::S_CH2A_COUNTS};
      cdd_pkg::IDX_CH2B_COUNTS: reg_slot = {1'b1, cdd_pkg::S_CH2B_COUNTS};
      cdd_pkg::IDX_CH2_BYPASS:  reg_slot = {1'b1, cdd_pkg::S_CH2_BYPASS};
      cdd_pkg::IDX_CH2_CTRL:    reg_slot = {1'b1, cdd_pkg::S_CH2_CTRL};
      cdd_pkg::IDX_CH3A_COUNTS: reg_slot = {1'b1, cdd_pkg::S_CH3A_COUNTS};
      cdd_pkg::IDX_CH3B_COUNTS: reg_slot = {1'b1, cdd_pkg::S_CH3B_COUNTS};
      cdd_pkg::IDX_CH3_BYPASS:  reg_slot = {1'b1, cdd_pkg::S_CH3_BYPASS};
      cdd_pkg::IDX_CH3_CTRL:    reg_slot = {1'b1, cdd_pkg::S_CH3_CTRL};
      cdd_pkg::IDX_PREDIV:      reg_slot = {1'b1, cdd_pkg::S_PREDIV};
      cdd_pkg::IDX_SOURCE:      reg_slot = {1'b1, cdd_pkg::S_SOURCE};
      default:                  reg_slot = 5'h00;
    endcase
  endfunction : reg_slot

  function automatic cdd_pkg::cdd_stage_cfg_t stage_cfg(
    input logic [7:0] counts,
    input logic       byp,
    input logic       dcc_off,
    input logic [7:0] phase
  );
    cdd_pkg::cdd_stage_cfg_t c;
    c.high_cnt = counts[cdd_pkg::HIGH_CNT_LSB +: 4];
    c.low_cnt = counts[cdd_pkg::LOW_CNT_LSB +: 4];
    c.bypass = byp;
    c.duty_correct_disable = dcc_off;
    c.start_high_flag = phase[cdd_pkg::START_HIGH_BIT];
    c.phase_delay_field = phase[cdd_pkg::PHASE_LSB +: 4];
    stage_cfg = c;
  endfunction : stage_cfg

  // ---------------------------------------------------------------
  // source select and channel input
  // ---------------------------------------------------------------
  always_comb begin
    src_sel = st.regs[cdd_pkg::S_SOURCE][1:0];
    src_legal = (src_sel != cdd_pkg::SRC_ILLEGAL);  // RULE21
    pre_used = (src_sel == cdd_pkg::SRC_EXT_PRE) || (src_sel == cdd_pkg::SRC_OSC_PRE);  // RULE1
    src_lvl = src_legal && ((src_sel == cdd_pkg::SRC_OSC_PRE) ? osc_clk_i : ext_clk_i);  // RULE1
    src_rise = src_lvl & ~st.src_prev;
    src_fall = ~src_lvl & st.src_prev;
    if (st.regs[cdd_pkg::S_PREDIV][2:0] > (cdd_pkg::PREDIV_MAX - cdd_pkg::PREDIV_BASE)) begin
      pd_ratio = cdd_pkg::PREDIV_MAX;
    end else begin
      pd_ratio = st.regs[cdd_pkg::S_PREDIV][2:0] + cdd_pkg::PREDIV_BASE;  // RULE5
    end
    pd_next = (st.pd_cnt == pd_ratio - 3'h1) ? 3'h0 : st.pd_cnt + 3'h1;
    // pre-divider output feeds the channels when used
    ch_in = pre_used ? st.pd_raw : src_lvl;  // RULE4 RULE21
    ch_corr = pre_used ? st.pd_corr : src_lvl;  // RULE17
  end

  // ---------------------------------------------------------------
  // channel divider stages
  // ---------------------------------------------------------------
  always_comb begin
    cfg[0] = stage_cfg(st.regs[cdd_pkg::S_CH0_COUNTS],  // RULE7
                       st.regs[cdd_pkg::S_CH0_PHASE][cdd_pkg::BYPASS_BIT],
                       st.regs[cdd_pkg::S_CH0_CTRL][cdd_pkg::DCC_OFF_BIT],
                       st.regs[cdd_pkg::S_CH0_PHASE]);  // RULE22
    cfg[1] = stage_cfg(st.regs[cdd_pkg::S_CH1_COUNTS],  // RULE8
                       st.regs[cdd_pkg::S_CH1_PHASE][cdd_pkg::BYPASS_BIT],
                       st.regs[cdd_pkg::S_CH1_CTRL][cdd_pkg::DCC_OFF_BIT],
                       st.regs[cdd_pkg::S_CH1_PHASE]);  // RULE22
    cfg[2] = stage_cfg(st.regs[cdd_pkg::S_CH2A_COUNTS],
                       st.regs[cdd_pkg::S_CH2_BYPASS][cdd_pkg::STAGE_A_BYP],
                       st.regs[cdd_pkg::S_CH2_CTRL][cdd_pkg::DCC_OFF_BIT], 8'h00);
    cfg[3] = stage_cfg(st.regs[cdd_pkg::S_CH2B_COUNTS],
                       st.regs[cdd_pkg::S_CH2_BYPASS][cdd_pkg::STAGE_B_BYP],
                       st.regs[cdd_pkg::S_CH2_CTRL][cdd_pkg::DCC_OFF_BIT], 8'h00);
    cfg[4] = stage_cfg(st.regs[cdd_pkg::S_CH3A_COUNTS],
                       st.regs[cdd_pkg::S_CH3_BYPASS][cdd_pkg::STAGE_A_BYP],
                       st.regs[cdd_pkg::S_CH3_CTRL][cdd_pkg::DCC_OFF_BIT], 8'h00);
    cfg[5] = stage_cfg(st.regs[cdd_pkg::S_CH3B_COUNTS],
                       st.regs[cdd_pkg::S_CH3_BYPASS][cdd_pkg::STAGE_B_BYP],
                       st.regs[cdd_pkg::S_CH3_CTRL][cdd_pkg::DCC_OFF_BIT], 8'h00);
    // second stages of channels 2 and 3 take the first stage's output
    stg_in = {stg_out[4], ch_in, stg_out[2], ch_in, ch_in, ch_in};  // RULE6
    stg_corr = {stg_out[4], ch_corr, stg_out[2], ch_corr, ch_corr, ch_corr};
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_stage
      cdd_div_stage u_stage (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .sync_i    (st.sync),
        .cfg_i     (cfg[g]),
        .in_i      (stg_in[g]),
        .in_corr_i (stg_corr[g]),
        .out_o     (stg_out[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // register bus, pre-divider, output registers
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    idx = wb_adr_i[11:2];
    {hit, slot} = reg_slot(idx);
    req = wb_cyc_i & wb_stb_i & ~st.ack;
    next_st.ack = req;
    next_st.sync = 1'b0;
    next_st.src_prev = src_lvl;
    if (req) begin
      if (wb_we_i && wb_sel_i[0]) begin
        if (hit) begin
          next_st.regs[slot] = wb_dat_i[7:0];
        end else if (idx == cdd_pkg::IDX_SYNC_CMD) begin
          next_st.sync = wb_dat_i[cdd_pkg::SYNC_BIT];  // RULE20
        end
      end
      if (hit) begin
        next_st.rdata = st.regs[slot];
      end else if (idx == cdd_pkg::IDX_STATUS) begin
        next_st.rdata = {3'h0, ~src_legal, st.outs[6], st.outs[4], st.outs[2], st.outs[0]};
      end else begin
        next_st.rdata = 8'h00;
      end
    end
    // pre-divider: raw high for floor(r/2), corrected adds half a source period when r is odd
    if (st.sync || !pre_used) begin
      next_st.pd_cnt = pd_ratio - 3'h1;
      next_st.pd_raw = 1'b0;
      next_st.pd_corr = 1'b0;
      next_st.pd_pend = 1'b0;
    end else begin
      if (src_rise) begin
        next_st.pd_cnt = pd_next;  // RULE5
        if (pd_next == 3'h0) begin
          next_st.pd_raw = 1'b1;
          next_st.pd_corr = 1'b1;
        end else if (pd_next == {1'b0, pd_ratio[2:1]}) begin
          next_st.pd_raw = 1'b0;  // RULE16
          if (pd_ratio[0]) begin
            next_st.pd_pend = 1'b1;  // RULE23
          end else begin
            next_st.pd_corr = 1'b0;
          end
        end
      end
      if (src_fall && st.pd_pend) begin
        next_st.pd_corr = 1'b0;
        next_st.pd_pend = 1'b0;
      end
    end
    // direct route sends the pre-divider input to the pair
    if (st.regs[cdd_pkg::S_CH0_CTRL][cdd_pkg::DIRECT_BIT]) begin
      next_st.outs[1:0] = {2{src_lvl}};  // RULE2 RULE18
    end else begin
      next_st.outs[1:0] = {2{stg_out[0]}};
    end
    if (st.regs[cdd_pkg::S_CH1_CTRL][cdd_pkg::DIRECT_BIT]) begin
      next_st.outs[3:2] = {2{src_lvl}};  // RULE2 RULE18
    end else begin
      next_st.outs[3:2] = {2{stg_out[1]}};
    end
    next_st.outs[5:4] = {2{stg_out[3]}};  // RULE6
    next_st.outs[7:6] = {2{stg_out[5]}};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.sync <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o = {24'h000000, st.rdata};
  assign wb_ack_o = st.ack;
  assign clk_out_o = st.outs;

endmodule : cdd_top

// File: dv/cdd_top_sva.sv
// concurrent checks on the ports of cdd_top
`timescale 1ns/1ps

// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module cdd_top_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // clocks
  input wire logic        ext_clk_i,
  input wire logic        osc_clk_i,
  input wire logic [7:0]  clk_out_o
);
  logic [1:0] src;
  logic       dir0;
  logic       take;
  logic [2:0] quiet;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // shadow of source code and channel 0 direct bit
  assign take = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src  <= 2'h0;
      dir0 <= 1'b0;
    end else if (take && wb_adr_i[11:2] == cdd_pkg::IDX_SOURCE) begin
      src <= wb_dat_i[1:0];
    end else if (take && wb_adr_i[11:2] == cdd_pkg::IDX_CH0_CTRL) begin
      dir0 <= wb_dat_i[cdd_pkg::DIRECT_BIT];
    end
  end

  // cycles since the last write, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || take) begin
      quiet <= 3'h0;
    end else if (quiet != 3'h7) begin
      quiet <= quiet + 3'h1;
    end
  end

  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdata_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_pairs_equal: assert property (clk_out_o[0] == clk_out_o[1] && clk_out_o[2] == clk_out_o[3]
    && clk_out_o[4] == clk_out_o[5] && clk_out_o[6] == clk_out_o[7])
    else $error("outputs of one channel differ");
  a_high_min: assert property ($rose(clk_out_o[0]) && quiet == 3'h7 |=> clk_out_o[0])
    else $error("output high shorter than a source phase");
  a_illegal_hold: assert property (src == 2'h3 [*8] |=> $stable(clk_out_o))
    else $error("outputs move on illegal source");
  a_direct_ext: assert property ((dir0 && src == 2'h0) [*4] |->
    (clk_out_o[0] == $past(ext_clk_i, 1) || clk_out_o[0] == $past(ext_clk_i, 2)))
    else $error("direct route does not follow external clock");
endmodule : cdd_top_sva

bind cdd_top cdd_top_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
  .osc_clk_i(osc_clk_i), .clk_out_o(clk_out_o));

// File: dv/cdd_clk_sink.sv
// clock consumer model measuring high time and period of each output
`timescale 1ns/1ps

// ---------------------------------------------------------------
// sink
// ---------------------------------------------------------------
module cdd_clk_sink (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // observed clocks
  input  wire logic [7:0] clk_in_i,
  // last high time and period, in clk_i cycles
  output logic [7:0][11:0] high_len_o,
  output logic [7:0][11:0] period_len_o
);
  logic [7:0]       prev;
  logic [7:0][11:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev         <= '0;
      cnt          <= '0;
      high_len_o   <= '0;
      period_len_o <= '0;
    end else begin
      prev <= clk_in_i;
      for (int i = 0; i < 8; i++) begin
        cnt[i] <= (clk_in_i[i] && !prev[i]) ? 12'h001 : cnt[i] + 12'h001;
        if (clk_in_i[i] && !prev[i]) period_len_o[i] <= cnt[i];
        if (!clk_in_i[i] && prev[i]) high_len_o[i] <= cnt[i];
      end
    end
  end
endmodule : cdd_clk_sink

// File: dv/clock_distribution_dividers_tb.sv
// self-checking bench for the clock distribution dividers
`timescale 1ns/1ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end

module clock_distribution_dividers_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic             clk_i  = 1'b0;
  logic             rst_i  = 1'b1;
  logic             wb_cyc = 1'b0;
  logic             wb_stb = 1'b0;
  logic             wb_we  = 1'b0;
  logic [11:0]      wb_adr = 12'h000;
  logic [31:0]      wb_dat = 32'h0;
  logic [31:0]      wb_dat_o;
  logic             wb_ack;
  logic             ext    = 1'b0;
  logic             osc    = 1'b0;
  logic [7:0]       clk_out;
  logic [7:0]       prv    = 8'h00;
  logic [7:0][11:0] hi_len;
  logic [7:0][11:0] per_len;
  logic [7:0]       q;
  logic [9:0]       tab [8];
  int               errors = 0;
  int               compares = 0;
  int               ec = 0;

  cdd_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .ext_clk_i(ext), .osc_clk_i(osc),
    .clk_out_o(clk_out));
  cdd_clk_sink sink (.clk_i(clk_i), .rst_i(rst_i), .clk_in_i(clk_out),
    .high_len_o(hi_len), .period_len_o(per_len));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // sources: external period 4, oscillator period 6; run limit
  always @(posedge clk_i) begin
    ec  <= ec + 1;
    ext <= (ec % 4) > 1;
    osc <= (ec % 6) > 2;
    prv <= clk_out;
    if (ec == 40000) begin
      errors++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task xfer(input logic we, input logic [9:0] idx, input logic [7:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= {idx, 2'h0};
    wb_dat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : xfer

  task wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr

  task rdc(input logic [9:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(q, e, "register read")
  endtask : rdc

  task chk(input int b, input logic [11:0] p, input logic [11:0] h);
    repeat (130) @(posedge clk_i);
    `CHK(per_len[b], p, "output period")
    `CHK(hi_len[b], h, "output high time")
  endtask : chk

  // cycles from a channel 0 rise to the next channel 1 rise
  task gap(input int e);
    int n;
    int g;
    repeat (60) @(posedge clk_i);
    n = 0;
    g = 0;
    while (!(clk_out[0] === 1'b1 && prv[0] === 1'b0) && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    while (!(clk_out[2] === 1'b1 && prv[2] === 1'b0) && g < 200) begin
      @(posedge clk_i);
      g++;
    end
    `CHK(g, e, "phase gap")
  endtask : gap

  task finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    tab = '{cdd_pkg::IDX_CH0_COUNTS, cdd_pkg::IDX_CH0_PHASE, cdd_pkg::IDX_CH0_CTRL,
      cdd_pkg::IDX_CH1_COUNTS, cdd_pkg::IDX_CH1_PHASE, cdd_pkg::IDX_CH1_CTRL,
      cdd_pkg::IDX_PREDIV, cdd_pkg::IDX_SOURCE};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (tab[i]) rdc(tab[i], 8'h00);
    wr(10'h100, 8'hff);
    rdc(10'h100, 8'h00);
    foreach (tab[i]) begin
      wr(tab[i], tab[i][7:0]);
      rdc(tab[i], tab[i][7:0]);
      wr(tab[i], 8'h00);
    end
    wr(cdd_pkg::IDX_SYNC_CMD, 8'h01);
    chk(0, 12'd16, 12'd8);
    chk(2, 12'd16, 12'd8);
    chk(4, 12'd32, 12'd16);
    chk(6, 12'd32, 12'd16);
    wr(cdd_pkg::IDX_CH0_COUNTS, 8'h21);
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h01);
    chk(0, 12'd40, 12'd16);
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h00);
    chk(0, 12'd40, 12'd20);
    wr(cdd_pkg::IDX_CH0_PHASE, 8'h80);
    for (int k = 0; k < 5; k++) begin
      wr(cdd_pkg::IDX_PREDIV, 8'(k));
      chk(0, 12'(4 * (k + 2)), 12'(2 * (k + 2)));
    end
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h01);
    wr(cdd_pkg::IDX_PREDIV, 8'h01);
    chk(0, 12'd12, 12'd4);
    wr(cdd_pkg::IDX_PREDIV, 8'h03);
    chk(0, 12'd20, 12'd8);
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h00);
    wr(cdd_pkg::IDX_PREDIV, 8'h00);
    wr(cdd_pkg::IDX_SOURCE, 8'h01);
    chk(0, 12'd4, 12'd2);
    wr(cdd_pkg::IDX_CH0_COUNTS, 8'h00);
    wr(cdd_pkg::IDX_CH0_PHASE, 8'h00);
    chk(0, 12'd8, 12'd4);
    wr(cdd_pkg::IDX_SOURCE, 8'h02);
    chk(0, 12'd24, 12'd12);
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h02);
    wr(cdd_pkg::IDX_CH1_CTRL, 8'h02);
    chk(0, 12'd6, 12'd3);
    chk(2, 12'd6, 12'd3);
    wr(cdd_pkg::IDX_SOURCE, 8'h00);
    chk(0, 12'd4, 12'd2);
    wr(cdd_pkg::IDX_CH0_CTRL, 8'h00);
    wr(cdd_pkg::IDX_CH1_CTRL, 8'h00);
    wr(cdd_pkg::IDX_SOURCE, 8'h03);
    repeat (20) @(posedge clk_i);
    wr(cdd_pkg::IDX_SOURCE, 8'h00);
    wr(cdd_pkg::IDX_CH0_COUNTS, 8'h11);
    wr(cdd_pkg::IDX_CH1_COUNTS, 8'h11);
    wr(cdd_pkg::IDX_SYNC_CMD, 8'h01);
    gap(0);
    wr(cdd_pkg::IDX_CH1_PHASE, 8'h02);
    gap(0);
    wr(cdd_pkg::IDX_SYNC_CMD, 8'h01);
    gap(16);
    wr(cdd_pkg::IDX_CH1_PHASE, 8'h10);
    wr(cdd_pkg::IDX_SYNC_CMD, 8'h01);
    gap(16);
    finish_test();
  end
endmodule : clock_distribution_dividers_tb
